// ### include/wdt_ctrl_pkg.sv
// Constants, field positions and carrier types for the watchdog control and status block.
// Assumes an 8-bit special function register port with one-cycle write strobes from the core.
package wdt_ctrl_pkg;
	localparam logic [7:0] ADDR_KEY      = 8'hC7;
	localparam logic [7:0] ADDR_RESTART  = 8'hD7;
	localparam logic [7:0] ADDR_CONTROL  = 8'hD8;
	localparam logic [7:0] KEY_FIRST     = 8'hAA;
	localparam logic [7:0] KEY_SECOND    = 8'h55;
	localparam int         UNLOCK_CYCLES = 3;
	localparam int         BIT_POWER_UP  = 6;
	localparam int         BIT_TIMEOUT   = 3;
	localparam int         BIT_WDT_RESET = 2;
	localparam int         BIT_RST_EN    = 1;
	localparam int         BIT_RESTART   = 0;
	localparam int         BIT_LOADER    = 0;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic power_up;
		logic timeout;
		logic wdt_reset;
		logic rst_en;
	} wdt_flags_t;
endpackage : wdt_ctrl_pkg

// ### hdl/watchdog_control_status.sv
// Watchdog control and status registers with timed-access write protection.
// Assumes the core presents SFR writes as one-cycle strobes and distinguishes its reset causes.
`timescale 1ns/1ns
`default_nettype none
module watchdog_control_status #(
	parameter int UNLOCK_WINDOW = wdt_ctrl_pkg::UNLOCK_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire wdt_ctrl_pkg::sfr_req_t sfr_req,
	input  wire logic [7:0]            sfr_addr_rd,
	output logic [7:0]                 sfr_rdata,
	input  wire logic                  power_on_reset,
	input  wire logic                  external_reset,
	input  wire logic                  wdt_timeout,
	output logic                       counter_restart,
	output logic                       wdt_reset_req,
	output logic                       restart_from_loader,
	output wdt_ctrl_pkg::wdt_flags_t   flags
);
	import wdt_ctrl_pkg::*;

	// The window counter is four bits wide, and a zero window could never be used
	if (UNLOCK_WINDOW < 1 || UNLOCK_WINDOW > 15) begin : g_window_check
		$error("UNLOCK_WINDOW out of range");
	end

	// Bit positions that exist in each register; all others read as zero
	localparam logic [7:0] CONTROL_USED = 8'h4F;
	localparam logic [7:0] RESTART_USED = 8'h01;

	logic       key_half_r;
	logic       key_half_nxt;
	logic [3:0] window_r;
	logic [3:0] window_nxt;
	logic       unlocked;
	logic       key_first_seen;
	logic       key_second_seen;
	logic       wr_key;
	logic       wr_restart;
	logic       wr_control;
	logic       prot_wr;
	logic       prot_control;
	logic       prot_restart;
	logic       power_up_r;
	logic       power_up_nxt;
	logic       timeout_r;
	logic       timeout_nxt;
	logic       wdt_reset_r;
	logic       wdt_reset_nxt;
	logic       rst_en_r;
	logic       rst_en_nxt;
	logic       restart_r;
	logic       restart_nxt;
	logic       loader_r;
	logic       loader_nxt;
	logic       wdt_cause;
	logic [7:0] control_bits;
	logic [7:0] control_view;
	logic [7:0] restart_bits;
	logic [7:0] restart_view;

	assign wr_key          = sfr_req.wr && sfr_req.addr == ADDR_KEY;
	assign wr_restart      = sfr_req.wr && sfr_req.addr == ADDR_RESTART;
	assign wr_control      = sfr_req.wr && sfr_req.addr == ADDR_CONTROL;
	assign key_first_seen  = wr_key && sfr_req.wdata == KEY_FIRST;
	assign key_second_seen = wr_key && sfr_req.wdata == KEY_SECOND;
	assign unlocked        = window_r != 4'h0;
	assign prot_wr         = (wr_control || wr_restart) && unlocked;
	assign prot_control    = prot_wr && wr_control;
	assign prot_restart    = prot_wr && wr_restart;

	// Second key byte must follow the first in the very next cycle
	always_comb begin
		key_half_nxt = key_first_seen;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			key_half_r <= 1'b0;
		end else begin
			key_half_r <= key_half_nxt;
		end
	end

	// One protected write per unlock; the window closes on use or on expiry
	always_comb begin
		window_nxt = window_r;
		if (key_half_r && key_second_seen) begin
			window_nxt = 4'(UNLOCK_WINDOW);
		end else if (prot_wr) begin
			window_nxt = 4'h0;
		end else if (unlocked) begin
			window_nxt = window_r - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			window_r <= 4'h0;
		end else begin
			window_r <= window_nxt;
		end
	end

	// A reset is caused only while enabled; the cause is latched in the flag below
	assign wdt_cause     = wdt_timeout && rst_en_r;
	assign wdt_reset_req = wdt_cause;

	// Power-up flag: hardware only ever sets it
	always_comb begin
		power_up_nxt = power_up_r;
		if (power_on_reset) begin
			power_up_nxt = 1'b1;
		end else if (prot_control && !external_reset) begin
			power_up_nxt = sfr_req.wdata[BIT_POWER_UP];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_up_r <= 1'b1;
		end else begin
			power_up_r <= power_up_nxt;
		end
	end

	// Time-out flag; a time-out in the clearing cycle wins over the clear
	always_comb begin
		timeout_nxt = timeout_r;
		if (power_on_reset || external_reset) begin
			timeout_nxt = 1'b0;
		end else if (wdt_timeout) begin
			timeout_nxt = 1'b1;
		end else if (prot_control) begin
			timeout_nxt = sfr_req.wdata[BIT_TIMEOUT];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timeout_r <= 1'b0;
		end else begin
			timeout_r <= timeout_nxt;
		end
	end

	// Watchdog-reset flag; external reset keeps it, write is unprotected
	always_comb begin
		wdt_reset_nxt = wdt_reset_r;
		if (power_on_reset) begin
			wdt_reset_nxt = 1'b0;
		end else if (wdt_cause) begin
			wdt_reset_nxt = 1'b1;
		end else if (wr_control && !external_reset) begin
			wdt_reset_nxt = sfr_req.wdata[BIT_WDT_RESET];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdt_reset_r <= 1'b0;
		end else begin
			wdt_reset_r <= wdt_reset_nxt;
		end
	end

	// Reset enable survives external and watchdog resets
	always_comb begin
		rst_en_nxt = rst_en_r;
		if (power_on_reset) begin
			rst_en_nxt = 1'b0;
		end else if (prot_control && !external_reset) begin
			rst_en_nxt = sfr_req.wdata[BIT_RST_EN];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_en_r <= 1'b0;
		end else begin
			rst_en_r <= rst_en_nxt;
		end
	end

	// Restart strobe reads back as 1 for one cycle, then clears itself
	always_comb begin
		restart_nxt = 1'b0;
		if (!power_on_reset && !external_reset) begin
			restart_nxt = prot_control && sfr_req.wdata[BIT_RESTART];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= restart_nxt;
		end
	end
	assign counter_restart = restart_r;

	// Restart region is kept through power-on, external and watchdog resets; only rstn or a protected write of 0 clears it
	always_comb begin
		loader_nxt = loader_r;
		if (prot_restart) begin
			loader_nxt = sfr_req.wdata[BIT_LOADER];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loader_r <= 1'b0;
		end else begin
			loader_r <= loader_nxt;
		end
	end
	assign restart_from_loader = loader_r;

	assign flags = '{power_up: power_up_r, timeout: timeout_r, wdt_reset: wdt_reset_r, rst_en: rst_en_r};

	// Raw register images before the reserved positions are masked
	always_comb begin
		control_bits                = 8'h00;
		control_bits[BIT_POWER_UP]  = power_up_r;
		control_bits[BIT_TIMEOUT]   = timeout_r;
		control_bits[BIT_WDT_RESET] = wdt_reset_r;
		control_bits[BIT_RST_EN]    = rst_en_r;
		control_bits[BIT_RESTART]   = restart_r;
	end

	always_comb begin
		restart_bits             = 8'h00;
		restart_bits[BIT_LOADER] = loader_r;
	end

	// Masking per bit keeps reserved positions low even if an image grows a bit
	for (genvar i = 0; i < 8; i++) begin : g_read_mask
		assign control_view[i] = CONTROL_USED[i] ? control_bits[i] : 1'b0;
		assign restart_view[i] = RESTART_USED[i] ? restart_bits[i] : 1'b0;
	end

	// The write-only key register and unmapped addresses read as zero
	always_comb begin
		sfr_rdata = 8'h00;
		unique case (sfr_addr_rd)
			ADDR_CONTROL: begin
				sfr_rdata = control_view;
			end
			ADDR_RESTART: begin
				sfr_rdata = restart_view;
			end
			default: begin
				sfr_rdata = 8'h00;
			end
		endcase
	end
endmodule : watchdog_control_status
`default_nettype wire

// ### verif/wdt_ctrl_checker.sv
// Port-level checks for the watchdog control block.
// Bound onto the design top; watches its ports only.
`timescale 1ns/1ns
`default_nettype none
module wdt_ctrl_checker #(parameter int UNLOCK_WINDOW = 3) (
	input wire logic						clk,
	input wire logic						rstn,
	input wire wdt_ctrl_pkg::sfr_req_t		sfr_req,
	input wire logic [7:0]					sfr_addr_rd,
	input wire logic [7:0]					sfr_rdata,
	input wire logic						power_on_reset,
	input wire logic						external_reset,
	input wire logic						wdt_timeout,
	input wire logic						counter_restart,
	input wire logic						wdt_reset_req,
	input wire logic						restart_from_loader,
	input wire wdt_ctrl_pkg::wdt_flags_t	flags
);
	import wdt_ctrl_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_req; wdt_reset_req == (wdt_timeout && flags.rst_en); endproperty
	a_req: assert property (p_req) else $error("req");
	property p_watchdog_reset_flag; wdt_reset_req && !power_on_reset |=> flags.wdt_reset; endproperty
	a_watchdog_reset_flag: assert property (p_watchdog_reset_flag) else $error("watchdog_reset_flag");
	property p_por; power_on_reset |=> flags.power_up && !flags.wdt_reset && !flags.rst_en; endproperty
	a_por: assert property (p_por) else $error("por");
	property p_pu; $fell(flags.power_up) |-> $past(sfr_req.wr); endproperty
	a_pu: assert property (p_pu) else $error("pu");
	property p_rwt; counter_restart |-> $past(sfr_req.wdata[0]) ##1 !counter_restart; endproperty
	a_rwt: assert property (p_rwt) else $error("rwt");
	property p_ext; external_reset && !wdt_timeout && !power_on_reset |=> !flags.timeout && $stable(flags.rst_en);
	endproperty
	a_ext: assert property (p_ext) else $error("ext");
	property p_rsv; sfr_addr_rd == ADDR_CONTROL |-> (sfr_rdata & 8'hB0) == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_ld; $changed(restart_from_loader) |-> $past(sfr_req.wr && sfr_req.addr == ADDR_RESTART); endproperty
	a_ld: assert property (p_ld) else $error("ld");
	cover property (wdt_reset_req);
	cover property (counter_restart);
	cover property (external_reset);
endmodule : wdt_ctrl_checker
bind watchdog_control_status wdt_ctrl_checker #(.UNLOCK_WINDOW(UNLOCK_WINDOW)) i_wdt_ctrl_checker (.*);
`default_nettype wire

// ### verif/watchdog_control_status_test.sv
// Bench for the watchdog control block: register writes, reads and reset causes.
// Inputs change 1 ns after a rising edge, or 2 ns after it when a read came first; idle cycles write to unmapped 00.
`timescale 1ns/1ns
`default_nettype none
module watchdog_control_status_test;
	import wdt_ctrl_pkg::*;
	logic		clk = 1'h0, rstn = 1'h0;
	logic [2:0]	ev = 3'h0;
	logic [7:0]	ra = 8'h00, rd;
	sfr_req_t	rq = '0;
	int			n_fail = 0, checks_done = 0;
	watchdog_control_status i_watchdog_control_status (.clk(clk), .rstn(rstn), .sfr_req(rq), .sfr_addr_rd(ra),
		.sfr_rdata(rd), .power_on_reset(ev[2]), .external_reset(ev[1]), .wdt_timeout(ev[0]), .counter_restart(),
		.wdt_reset_req(), .restart_from_loader(), .flags());
	initial forever #25 clk = ~clk;
	task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [2:0] e = 3'h0);
		rq = '{1'h1, a, d};
		ev = e;
		@(posedge clk);
		#1;
	endtask : put
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		ra = a;
		#1 checks_done++;
		if (rd !== exp) n_fail++;
		if (rd !== exp) $display("BAD %0t read %h want %h", $time, rd, exp);
	endtask : rdc
	task automatic give_verdict;
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (10) @(posedge clk);
		#1 rstn = 1'h1;
		put(8'h00, 8'h00, 3'h1);
		put(8'hD8, 8'h0B);
		rdc(8'hD8, 8'h48);
		put(8'hC7, KEY_FIRST);
		put(8'hC7, KEY_SECOND);
		put(8'hD8, 8'hB3);
		rdc(8'hD8, 8'h03);
		put(8'hD7, 8'h01);
		rdc(8'hD7, 8'h00);
		put(8'h00, 8'h00, 3'h1);
		rdc(8'hD8, 8'h0E);
		put(8'h00, 8'h00, 3'h2);
		rdc(8'hD8, 8'h06);
		put(8'hD8, 8'h00);
		rdc(8'hD8, 8'h02);
		put(8'hC7, KEY_FIRST);
		put(8'hC7, KEY_SECOND);
		put(8'hD7, 8'hFF);
		rdc(8'hD7, 8'h01);
		put(8'h00, 8'h00, 3'h4);
		rdc(8'hD8, 8'h40);
		give_verdict();
	end
endmodule : watchdog_control_status_test
`default_nettype wire
